// file: dac_i2c_write_port.sv
// Serial write port of a quad 10-bit converter: address, command, data.
// Assumes SCL and SDA are slow pins sampled by clk_i; SDA is open drain.
//
// Overview of operation
// - High byte is upper eight code bits.
// - Command bit zero set: power-down mode bits.
// - Low byte top two bits; rest ignored.
// - Apply value at acknowledge falling edge.
// - Staging and output registers cleared at reset.
// - One 12-bit staging register per channel.
// - Four 12-bit output registers, immediate effect.
// - Command byte held for decoding.
// - Command selects mode and channel.
// - Data pairs repeat until stop/restart.
// - Power-down takes exactly two bytes.
// - Select bits choose channel A to D.
// - Load field ten loads all outputs.
// - Broadcast with upper select bit clear updates all from staging.
// - Broadcast power-down with upper select bit set powers down all.
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_write_port
   import dac_port_pkg::*;
(
   input wire logic clk_i, // System clock, 200 MHz.
   input wire logic resetn_i, // Asynchronous reset, active low.
   input wire logic scl_i, // Serial clock pin.
   input wire logic sda_i, // Serial data pin level.
   output logic sda_o, // Serial data drive value, always low.
   output logic sda_oe_o, // Serial data drive enable, high pulls low.
   input wire logic address_pin_upper, // Upper address strap.
   input wire logic address_pin_lower, // Lower address strap.
   output logic [dac_port_pkg::CHANNELS*dac_port_pkg::WORD_W-1:0] channel_output_o, // Output words.
   output logic [dac_port_pkg::CHANNELS*dac_port_pkg::WORD_W-1:0] channel_staging_o // Staging words.
);
   import dac_port_pkg::*;

   // Byte phases of a write transaction.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD = 3'b010,
      ST_HIGH = 3'b011,
      ST_LOW = 3'b100,
      ST_IGNORE = 3'b101
   } phase_type;

   logic [1:0] pins_sync; // Synchronised SCL and SDA.
   logic scl_s; // Synchronised serial clock.
   logic sda_s; // Synchronised serial data.
   logic scl_prev_q; // Previous serial clock sample.
   logic sda_prev_q; // Previous serial data sample.
   logic scl_rise; // Serial clock rising edge.
   logic scl_fall; // Serial clock falling edge.
   logic start_ev; // Start or repeated start seen.
   logic stop_ev; // Stop seen.
   phase_type phase_q; // Current byte phase.
   logic [3:0] bit_cnt_q; // Bits received in the current byte.
   logic [7:0] shift_q; // Incoming byte shifter.
   logic ack_slot_q; // Eighth bit taken; the next rising edge is the acknowledge clock.
   logic ack_drive_q; // Pulling SDA low in the acknowledge slot.
   logic [7:0] command_byte_reg; // Held command byte.
   logic [7:0] data_high_byte_reg; // Held high data byte.
   logic [7:0] data_low_byte_reg; // Held low data byte.
   logic byte_done; // Eighth bit sampled on this edge.
   logic [7:0] byte_now; // Byte including the bit sampled now.
   logic addr_match; // Address byte matches this device.
   logic low_done_q; // Low byte finished, waiting for ack fall.
   logic [1:0] load_field; // Load field of the command.
   logic [SEL_W-1:0] channel_sel; // Channel selected by the command.
   logic power_down_select_bit; // Power-down select bit.
   logic command_bit_zero; // Lowest command bit.
   logic broadcast; // Broadcast command active.
   logic [WORD_W-1:0] new_word; // Word assembled from the data pair.
   logic [CHANNELS-1:0] stage_we; // Staging write strobes.
   logic [CHANNELS-1:0] out_we; // Output load strobes.
   logic [CHANNELS-1:0] out_direct; // Output takes the new word.
   logic pd_all; // Power down all channels.
   logic apply_now; // Acknowledge falling edge after a low byte.
   logic ack_pending_q; // A taken byte awaits its acknowledge.

   // Both pins cross into the clock domain through two flip-flops.
   sync_2ff #(
      .WIDTH(2)
   ) u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .async_i({scl_i, sda_i}),
      .sync_o(pins_sync)
   );
   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   // Previous samples of the synchronised pins for edge finding.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // Edges and bus conditions; SDA moving while SCL is high frames a transfer.
   assign scl_rise = scl_s && !scl_prev_q;
   assign scl_fall = !scl_s && scl_prev_q;
   assign start_ev = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_ev = scl_s && scl_prev_q && !sda_prev_q && sda_s;
   assign byte_now = {shift_q[6:0], sda_s};
   assign byte_done = scl_rise && !ack_slot_q && (bit_cnt_q == BIT_LAST);

   assign addr_match = (byte_now[7:3] == ADDR_FIXED) &&
                       (byte_now[ADDR_PIN_HI] == address_pin_upper) &&
                       (byte_now[ADDR_PIN_LO] == address_pin_lower) &&
                       (byte_now[ADDR_RW] == 1'b0);

   // Bit counter and shifter; the ninth clock is the acknowledge slot.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bit_cnt_q <= BIT_FIRST;
         shift_q <= BYTE_RESET;
         ack_slot_q <= 1'b0;
      end else if (start_ev || stop_ev) begin
         bit_cnt_q <= BIT_FIRST;
         ack_slot_q <= 1'b0;
      end else if (scl_rise && !ack_slot_q) begin
         shift_q <= byte_now;
         bit_cnt_q <= byte_done ? BIT_FIRST : bit_cnt_q + 4'h1;
         ack_slot_q <= byte_done;
      end else if (scl_rise && ack_slot_q) begin
         // The ninth rising edge is the acknowledge clock, not a data bit.
         ack_slot_q <= 1'b0;
      end
   end

   // Phase machine over address, command and data bytes.
   // address then command.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase_q <= ST_IDLE;
      end else if (start_ev) begin
         phase_q <= ST_ADDR;
      end else if (stop_ev) begin
         phase_q <= ST_IDLE;
      end else if (byte_done) begin
         unique case (phase_q)
            ST_IDLE: phase_q <= ST_IDLE;
            ST_ADDR: phase_q <= addr_match ? ST_CMD : ST_IGNORE;
            ST_CMD: phase_q <= ST_HIGH;
            ST_HIGH: phase_q <= ST_LOW;
            ST_LOW: phase_q <= command_byte_reg[CMD_PD] ? ST_IGNORE : ST_HIGH;
            ST_IGNORE: phase_q <= ST_IGNORE;
            default: phase_q <= ST_IDLE;
         endcase
      end
   end

   // acknowledge drive.
   // Pull SDA low through the acknowledge clock of every byte taken.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_drive_q <= 1'b0;
      end else if (start_ev || stop_ev) begin
         ack_drive_q <= 1'b0;
      end else if (scl_fall && ack_slot_q && ack_pending_q) begin
         // The fall after the eighth bit opens the slot; the next fall closes it.
         ack_drive_q <= 1'b1;
      end else if (scl_fall && ack_drive_q) begin
         ack_drive_q <= 1'b0;
      end
   end

   // Marks a byte that this device accepts, so its slot is driven.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_pending_q <= 1'b0;
      end else if (start_ev || stop_ev) begin
         ack_pending_q <= 1'b0;
      end else if (byte_done) begin
         ack_pending_q <= (phase_q == ST_ADDR) ? addr_match :
                          (phase_q == ST_CMD || phase_q == ST_HIGH || phase_q == ST_LOW);
      end else if (ack_drive_q && scl_fall) begin
         ack_pending_q <= 1'b0;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = ack_drive_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         command_byte_reg <= BYTE_RESET;
         data_high_byte_reg <= BYTE_RESET;
         data_low_byte_reg <= BYTE_RESET;
      end else if (byte_done) begin
         if (phase_q == ST_CMD) begin
            command_byte_reg <= byte_now;
         end
         if (phase_q == ST_HIGH) begin
            data_high_byte_reg <= byte_now;
         end
         if (phase_q == ST_LOW) begin
            data_low_byte_reg <= byte_now;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         low_done_q <= 1'b0;
      end else if (start_ev || stop_ev) begin
         low_done_q <= 1'b0;
      end else if (byte_done && phase_q == ST_LOW) begin
         low_done_q <= 1'b1;
      end else if (apply_now) begin
         low_done_q <= 1'b0;
      end
   end
   // The second falling edge after the eighth bit closes the ack clock.
   assign apply_now = low_done_q && scl_fall && ack_drive_q;

   assign load_field = command_byte_reg[CMD_LOAD_HI:CMD_LOAD_LO];
   assign channel_sel = command_byte_reg[CMD_SEL_HI:CMD_SEL_LO];
   assign command_bit_zero = command_byte_reg[CMD_PD];
   assign power_down_select_bit = command_bit_zero;
   assign broadcast = (load_field == LOAD_BCAST);

   assign new_word = power_down_select_bit ?
      {data_high_byte_reg[7:6], WORD_RESET[CODE_W-1:0]} :
      {WORD_RESET[WORD_W-1:CODE_W], data_high_byte_reg, data_low_byte_reg[7:6]};

   // Strobes toward the channel bank, each one cycle at the apply edge.
   always_comb begin
      stage_we = '0;
      out_we = '0;
      out_direct = '0;
      pd_all = 1'b0;
      if (apply_now) begin
         unique case (load_field)
            LOAD_TEMP: begin
               stage_we[channel_sel] = 1'b1;
            end
            LOAD_ONE: begin
               stage_we[channel_sel] = 1'b1;
               out_we[channel_sel] = 1'b1;
               out_direct[channel_sel] = 1'b1;
            end
            LOAD_ALL: begin
               stage_we[channel_sel] = 1'b1;
               out_we = '1;
               out_direct[channel_sel] = 1'b1;
            end
            LOAD_BCAST: begin
               if (!command_byte_reg[CMD_SEL_HI]) begin
                  out_we = '1;
               end else if (power_down_select_bit) begin
                  pd_all = 1'b1;
               end else begin
                  stage_we = '1;
                  out_we = '1;
                  out_direct = '1;
               end
            end
         endcase
      end
   end

   // The staging and applied words of all four channels.
   dac_channel_bank u_bank (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .stage_we_i(stage_we),
      .stage_word_i(new_word),
      .out_we_i(out_we),
      .out_direct_i(out_direct),
      .pd_all_i(pd_all),
      .pd_mode_i(data_high_byte_reg[7:6]),
      .stage_o(channel_staging_o),
      .out_o(channel_output_o)
   );
endmodule
`default_nettype wire

// file: dac_port_pkg.sv
// Package of constants for the quad DAC serial write port.
// Assumes a single system clock; the serial link is sampled, not clocked.
package dac_port_pkg;
   localparam int CHANNELS = 4; // Number of converter channels.
   localparam int CODE_W = 10; // Width of the conversion code.
   localparam int WORD_W = 12; // Width of staging and output words.
   localparam int PD_W = 2; // Width of the power-down field.
   localparam int BYTE_W = 8; // Width of one serial byte.
   localparam int SEL_W = 2; // Width of the channel index.
   localparam logic [4:0] ADDR_FIXED = 5'h13; // Fixed upper address bits.
   localparam int ADDR_PIN_HI = 2; // Address byte bit of the upper pin.
   localparam int ADDR_PIN_LO = 1; // Address byte bit of the lower pin.
   localparam int ADDR_RW = 0; // Direction bit in the address byte.
   localparam int CMD_LOAD_HI = 5; // Upper load field bit.
   localparam int CMD_LOAD_LO = 4; // Lower load field bit.
   localparam int CMD_SEL_HI = 2; // Upper channel select bit.
   localparam int CMD_SEL_LO = 1; // Lower channel select bit.
   localparam int CMD_PD = 0; // Power-down select bit.
   localparam logic [1:0] LOAD_TEMP = 2'h0; // Write staging only.
   localparam logic [1:0] LOAD_ONE = 2'h1; // Write and load one channel.
   localparam logic [1:0] LOAD_ALL = 2'h2; // Write and load all channels.
   localparam logic [1:0] LOAD_BCAST = 2'h3; // Broadcast command.
   localparam logic [11:0] WORD_RESET = 12'h000; // Power-on word value.
   localparam logic [7:0] BYTE_RESET = 8'h00; // Power-on byte value.
   localparam logic [3:0] BIT_LAST = 4'h7; // Index of the eighth bit.
   localparam logic [3:0] BIT_FIRST = 4'h0; // Index of the first bit.
endpackage

// file: sync_2ff.sv
// Two flip-flop synchroniser for a vector of slow inputs.
// Assumes the inputs change far slower than the sampling clock.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 2 // Number of bits synchronised.
) (
   input wire logic clk_i, // Sampling clock.
   input wire logic resetn_i, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] async_i, // Raw inputs.
   output logic [WIDTH-1:0] sync_o // Synchronised inputs.
);
   logic [WIDTH-1:0] meta_q; // First stage, read only by the second.
   // The reset value is high because idle bus lines are high.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q <= '1;
         sync_o <= '1;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: dac_channel_bank.sv
// Per-channel staging and output registers of the converter.
// Assumes one-cycle strobes from the serial port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dac_channel_bank
   import dac_port_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic resetn_i, // Asynchronous reset, active low.
   input wire logic [dac_port_pkg::CHANNELS-1:0] stage_we_i, // Staging write strobes.
   input wire logic [dac_port_pkg::WORD_W-1:0] stage_word_i, // Word to stage.
   input wire logic [dac_port_pkg::CHANNELS-1:0] out_we_i, // Output load strobes.
   input wire logic [dac_port_pkg::CHANNELS-1:0] out_direct_i, // Load from word, not staging.
   input wire logic pd_all_i, // Power down every channel.
   input wire logic [dac_port_pkg::PD_W-1:0] pd_mode_i, // Mode used by pd_all_i.
   output logic [dac_port_pkg::CHANNELS*dac_port_pkg::WORD_W-1:0] stage_o, // Staging words.
   output logic [dac_port_pkg::CHANNELS*dac_port_pkg::WORD_W-1:0] out_o // Output words.
);
   genvar ch;
   // Each channel keeps its own pair of words.
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
         logic [WORD_W-1:0] stage_q; // Staging word.
         logic [WORD_W-1:0] out_q; // Applied word.
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               stage_q <= WORD_RESET;
            end else if (stage_we_i[ch]) begin
               stage_q <= stage_word_i;
            end
         end
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               out_q <= WORD_RESET;
            end else if (pd_all_i) begin
               out_q <= {pd_mode_i, out_q[CODE_W-1:0]};
            end else if (out_we_i[ch]) begin
               out_q <= out_direct_i[ch] ? stage_word_i : stage_q;
            end
         end
         assign stage_o[ch*WORD_W +: WORD_W] = stage_q;
         assign out_o[ch*WORD_W +: WORD_W] = out_q;
      end
   endgenerate
endmodule
`default_nettype wire

// file: dac_port_monitor.sv
// Checker for the serial write port, watching only its ports.
// Assumes the bench binds it to the port module.
`timescale 1ns/1ps
`default_nettype none
module dac_port_monitor
   import dac_port_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic resetn_i, // Reset, active low.
   input wire logic scl_i, // Serial clock.
   input wire logic sda_i, // Data wire level.
   input wire logic sda_o, // Data drive value.
   input wire logic sda_oe_o, // Data drive enable.
   input wire logic address_pin_upper, // Upper strap.
   input wire logic address_pin_lower, // Lower strap.
   input wire logic [dac_port_pkg::CHANNELS*dac_port_pkg::WORD_W-1:0] channel_output_o, // Out.
   input wire logic [dac_port_pkg::CHANNELS*dac_port_pkg::WORD_W-1:0] channel_staging_o // Stage.
);
   import dac_port_pkg::*;
   logic pd_bad; // A staged power-down word that also carries code bits.
   // Scans every staging word for mode bits beside a nonzero code.
   always_comb begin
      pd_bad = 1'b0;
      for (int c = 0; c < CHANNELS; c++) begin
         if (|channel_staging_o[c*WORD_W+CODE_W +: PD_W] && |channel_staging_o[c*WORD_W +: CODE_W])
            pd_bad = 1'b1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sda_low_a: assert property (sda_oe_o |-> !sda_o)
      else $error("data drive value not low");
   ack_scl_low_a: assert property ($rose(sda_oe_o) |-> !scl_i)
      else $error("acknowledge begun with clock high");
   ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
      else $error("acknowledge too short");
   ack_release_a: assert property ($rose(sda_oe_o) |-> ##[8:40] !sda_oe_o)
      else $error("acknowledge never released");
   out_on_ack_a: assert property (!$stable(channel_output_o) |-> !scl_i && $past(sda_oe_o, 4))
      else $error("output words changed outside an acknowledge");
   stage_on_ack_a: assert property (!$stable(channel_staging_o) |-> !scl_i && $past(sda_oe_o, 4))
      else $error("staging words changed outside an acknowledge");
   reset_clear_a: assert property ($rose(resetn_i) |-> channel_output_o == '0 && channel_staging_o == '0)
      else $error("words not cleared by reset");
   pd_code_zero_a: assert property (!pd_bad)
      else $error("power-down word staged with code bits");
   cover property ($rose(sda_oe_o));
   cover property (!$stable(channel_output_o));
   cover property (!$stable(channel_staging_o) && $stable(channel_output_o));
endmodule
`default_nettype wire

// file: i2c_master_model.sv
// Behavioural bus master that writes bytes to the port.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   input wire logic clk_i, // Bench clock used for pacing.
   input wire logic sda_i, // Resolved data wire.
   output logic scl_o, // Serial clock, 80 ns period in frames.
   output logic sda_o // Data drive, low pulls the wire.
);
   // Idle bus: both lines released.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Waits a number of clock cycles.
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic start();
      sda_o <= 1'b1;
      hold(4);
      scl_o <= 1'b1;
      hold(8);
      sda_o <= 1'b0;
      hold(8);
      scl_o <= 1'b0;
      hold(4);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_o <= b[i];
         hold(4);
         scl_o <= 1'b1;
         hold(8);
         scl_o <= 1'b0;
         hold(4);
      end
      sda_o <= 1'b1;
      hold(4);
      scl_o <= 1'b1;
      hold(4);
      ack = ~sda_i;
      hold(4);
      scl_o <= 1'b0;
      hold(4);
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      sda_o <= 1'b0;
      hold(4);
      scl_o <= 1'b1;
      hold(8);
      sda_o <= 1'b1;
      hold(8);
   endtask
endmodule
`default_nettype wire

// file: tb_quad_dac_i2c_write_port.sv
// Self-checking bench for the quad converter serial write port.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_quad_dac_i2c_write_port;
   import dac_port_pkg::*;
   logic clk_i = 1'b0; // Bench clock.
   logic resetn_i = 1'b0; // Reset, active low.
   logic pin_hi = 1'b0; // Upper strap.
   logic pin_lo = 1'b0; // Lower strap.
   logic scl; // Serial clock.
   logic m_sda; // Master drive.
   logic dut_sda; // Port drive value.
   logic dut_oe; // Port drive enable.
   logic sda_w; // Resolved wire.
   logic [CHANNELS*WORD_W-1:0] out_w; // Output words.
   logic [CHANNELS*WORD_W-1:0] stage_w; // Staging words.
   logic [WORD_W-1:0] e_out [CHANNELS]; // Expected outputs.
   logic [WORD_W-1:0] e_stg [CHANNELS]; // Expected staging.
   logic [31:0] seed = 32'h0000005B; // Fixed seed.
   logic [31:0] r; // Random draw.
   logic ack; // Acknowledge seen.
   int error_cnt = 0; // Mismatches.
   int compares = 0; // Comparisons.
   int cycles = 0; // Cycles run.
   // Open drain with pull-up: either side may pull low.
   assign sda_w = m_sda & ~(dut_oe & ~dut_sda);
   always #2.5 clk_i = ~clk_i;
   i2c_master_model m_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
   dac_i2c_write_port dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w),
      .sda_o(dut_sda), .sda_oe_o(dut_oe), .address_pin_upper(pin_hi),
      .address_pin_lower(pin_lo), .channel_output_o(out_w), .channel_staging_o(stage_w));
   // Xorshift generator.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Power-on expectation: all words zero.
   function automatic void clear_exp();
      for (int c = 0; c < CHANNELS; c++) begin
         e_out[c] = WORD_RESET;
         e_stg[c] = WORD_RESET;
      end
   endfunction
   // Expected effect of one completed unit.
   function automatic void apply(input logic [7:0] cmd, input logic [7:0] hi, input logic [7:0] lo);
      logic [WORD_W-1:0] w;
      logic [1:0] sel;
      w = cmd[CMD_PD] ? {hi[7:6], 10'h000} : {2'h0, hi, lo[7:6]};
      sel = cmd[CMD_SEL_HI:CMD_SEL_LO];
      case (cmd[CMD_LOAD_HI:CMD_LOAD_LO])
         LOAD_BCAST: begin
            for (int c = 0; c < CHANNELS; c++) begin
               if (!cmd[CMD_SEL_HI]) e_out[c] = e_stg[c];
               else e_out[c][11:10] = hi[7:6];
            end
         end
         default: begin
            e_stg[sel] = w;
            if (cmd[CMD_LOAD_HI:CMD_LOAD_LO] == LOAD_ONE) e_out[sel] = w;
            if (cmd[CMD_LOAD_HI:CMD_LOAD_LO] == LOAD_ALL) e_out = e_stg;
         end
      endcase
   endfunction
   // Compares one value and counts it.
   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Compares all words against the expectation.
   task automatic check_words();
      for (int c = 0; c < CHANNELS; c++) begin
         check("output word", 48'(e_out[c]), 48'(out_w[c*WORD_W +: WORD_W]));
         check("staging word", 48'(e_stg[c]), 48'(stage_w[c*WORD_W +: WORD_W]));
      end
   endtask
   // Sends a byte and compares its acknowledge.
   task automatic put(input logic [7:0] b, input logic exp);
      m_u.send_byte(b, ack);
      check("acknowledge", 48'(exp), 48'(ack));
   endtask
   // Start, address, and command when the address is ours.
   task automatic begin_write(input logic [7:0] cmd, input logic [1:0] pins, input logic rw);
      m_u.start();
      put({ADDR_FIXED, pins, rw}, pins == {pin_hi, pin_lo} && !rw);
      if (pins == {pin_hi, pin_lo} && !rw) put(cmd, 1'b1);
   endtask
   // One high/low unit, then the words after its acknowledge.
   task automatic unit(input logic [7:0] cmd, input logic [7:0] hi, input logic [7:0] lo);
      put(hi, 1'b1);
      put(lo, 1'b1);
      apply(cmd, hi, lo);
      m_u.hold(4);
      check_words();
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   // Prints the counts and the verdict, then ends.
   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         $display("unexpected timeout: expected done, seen running");
         conclude();
      end
   end
   initial begin
      logic [7:0] cmd;
      clear_exp();
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      m_u.hold(4);
      check_words();
      done("reset");
      for (int t = 0; t < 16; t++) begin
         r = rnd();
         pin_hi <= r[8];
         pin_lo <= r[9];
         m_u.hold(1);
         cmd = {2'h0, 2'(r[1:0] % 3), 1'b0, r[3:2], r[4]};
         begin_write(cmd, {pin_hi, pin_lo}, 1'b0);
         if (cmd[CMD_PD]) begin
            unit(cmd, {r[6:5], 6'h00}, {2'h0, r[15:10]});
            if (r[16]) put(r[23:16], 1'b0);
         end else begin
            unit(cmd, r[23:16], r[31:24]);
            if (r[17]) unit(cmd, r[31:24], r[23:16]);
         end
         if (r[7]) m_u.stop();
         done("random write");
      end
      begin_write(8'h16, {pin_hi, pin_lo}, 1'b0);
      unit(8'h16, 8'hFF, 8'hFF);
      unit(8'h16, 8'h00, 8'h3F);
      begin_write(8'h02, {pin_hi, pin_lo}, 1'b0);
      unit(8'h02, 8'h5A, 8'hC0);
      put(8'hA5, 1'b1);
      m_u.stop();
      m_u.hold(8);
      check_words();
      done("corner data");
      begin_write(8'h30, {pin_hi, pin_lo}, 1'b0);
      unit(8'h30, 8'h00, 8'h00);
      m_u.stop();
      begin_write(8'h35, {pin_hi, pin_lo}, 1'b0);
      unit(8'h35, 8'hC0, 8'h00);
      m_u.stop();
      done("broadcast");
      begin_write(8'h12, ~{pin_hi, pin_lo}, 1'b0);
      put(8'h12, 1'b0);
      m_u.stop();
      begin_write(8'h12, {pin_hi, pin_lo}, 1'b1);
      m_u.stop();
      check_words();
      done("refused address");
      resetn_i <= 1'b0;
      m_u.hold(8);
      resetn_i <= 1'b1;
      clear_exp();
      m_u.hold(4);
      check_words();
      done("second reset");
      conclude();
   end
endmodule
bind dac_i2c_write_port dac_port_monitor mon_u (.clk_i(clk_i), .resetn_i(resetn_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .address_pin_upper(address_pin_upper), .address_pin_lower(address_pin_lower),
   .channel_output_o(channel_output_o), .channel_staging_o(channel_staging_o));
`default_nettype wire
